// >>> include/lsseq_regs.svh
// timing constants of the led string start-up sequencer
`ifndef LSSEQ_REGS_SVH
`define LSSEQ_REGS_SVH

// ==========================================================
// clock and timebase
`define LSSEQ_CLK_MHZ        100
`define LSSEQ_TICK_US        1
`define LSSEQ_TICK_CYCLES    (`LSSEQ_CLK_MHZ * `LSSEQ_TICK_US)
`define LSSEQ_US_PER_MS      1000

// ==========================================================
// sequence intervals as printed
`define LSSEQ_T_DETECT_US    256
`define LSSEQ_T_SOFTSTART_MS 128
`define LSSEQ_T_BLANK_MS     256
`define LSSEQ_T_SHDN_MS      32

// ==========================================================
// interval counts in timebase ticks
`define LSSEQ_DETECT_TICKS   (`LSSEQ_T_DETECT_US / `LSSEQ_TICK_US)
`define LSSEQ_SS_TICKS       (`LSSEQ_T_SOFTSTART_MS * `LSSEQ_US_PER_MS / `LSSEQ_TICK_US)
`define LSSEQ_BLANK_TICKS    (`LSSEQ_T_BLANK_MS * `LSSEQ_US_PER_MS / `LSSEQ_TICK_US)
`define LSSEQ_SHDN_TICKS     (`LSSEQ_T_SHDN_MS * `LSSEQ_US_PER_MS / `LSSEQ_TICK_US)

// ==========================================================
// widths and reset values
`define LSSEQ_CNT_W          20
`define LSSEQ_CODE_W         8
`define LSSEQ_NCH            4
`define LSSEQ_RST_USED       4'h0

`endif

// >>> include/lsseq_pkg.sv
// types of the led string start-up sequencer
`include "lsseq_regs.svh"
package lsseq_pkg;
   typedef logic [`LSSEQ_CNT_W-1:0] lsseq_cnt_t;
   typedef logic [`LSSEQ_CODE_W-1:0] lsseq_code_t;
   typedef enum logic [2:0] {
      LSSEQ_SHUTDOWN,
      LSSEQ_DETECT,
      LSSEQ_SOFTSTART,
      LSSEQ_REGULATE
   } lsseq_state_e;
endpackage

// >>> verilog/lsseq_timebase.sv
// free-running microsecond tick divider
`include "lsseq_regs.svh"
module lsseq_timebase
   import lsseq_pkg::*;
#(
   parameter int TICK_CYCLES = `LSSEQ_TICK_CYCLES
) (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   output logic      tick
);
   typedef struct packed {
      logic [15:0] div;
      logic        tick;
   } lsseq_tb_s;

   lsseq_tb_s r;
   lsseq_tb_s next_r;

   // ==========================================================
   // divider
   always_comb begin
      next_r      = r;
      next_r.tick = 1'b0;
      if (r.div == 16'(TICK_CYCLES - 1)) begin
         next_r.div  = 16'h0000;
         next_r.tick = 1'b1;
      end else begin
         next_r.div = r.div + 16'h0001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign tick = r.tick;
endmodule

// >>> verilog/lsseq_top.sv
// control sequencer of a four-channel led sink driver
// Operation
// - start only with enable high and supply good
// - detect channel use during 256 us window
// - sense below threshold means used, else unused
// - unused channels stay gated off after detection
// - soft-start holds feedback output at fixed high
// - then regulate against highest forward voltage string
// - open and short ignored until blanking expires
// - active open or short turns drivers off
// - short, open or overtemp pulls fault low
// - blanking time is 256 ms
// - full shutdown after enable low 32 ms
`include "lsseq_regs.svh"
module lsseq_top
   import lsseq_pkg::*;
#(
   parameter int TICK_CYCLES  = `LSSEQ_TICK_CYCLES,
   parameter int DETECT_TICKS = `LSSEQ_DETECT_TICKS,
   parameter int SS_TICKS     = `LSSEQ_SS_TICKS,
   parameter int BLANK_TICKS  = `LSSEQ_BLANK_TICKS,
   parameter int SHDN_TICKS   = `LSSEQ_SHDN_TICKS
) (
   input  wire logic                    sys_clk,
   input  wire logic                    sys_rst,
   input  wire logic                    en_pwm,
   input  wire logic                    supply_ok,
   input  wire logic [`LSSEQ_NCH-1:0]   cs_low,
   input  wire logic [`LSSEQ_NCH-1:0]   open_string_protection,
   input  wire logic [`LSSEQ_NCH-1:0]   shorted_string_protection,
   input  wire logic                    over_temp,
   input  wire lsseq_code_t [`LSSEQ_NCH-1:0] cathode_code,
   input  wire lsseq_code_t             headroom_setpoint,
   output logic [`LSSEQ_NCH-1:0]        gate_en,
   output logic [`LSSEQ_NCH-1:0]        chan_used,
   output logic                         feedback_force_high,
   output logic                         dynamic_headroom_regulation,
   output logic [1:0]                   ref_channel,
   output logic                         feedback_raise,
   output logic                         fault_out,
   output logic                         fault_oe,
   output logic                         active
);
   typedef struct packed {
      lsseq_state_e             st;
      logic [`LSSEQ_NCH-1:0]    used;
      lsseq_cnt_t               timer;
      lsseq_cnt_t               blank;
      lsseq_cnt_t               low_cnt;
      logic                     blank_done;
      logic [`LSSEQ_NCH-1:0]    gate;
      logic                     fb_force;
      logic                     fb_reg;
      logic [1:0]               ref_ch;
      logic                     fb_raise;
      logic                     fault_out;
      logic                     fault_oe;
      logic                     act;
   } lsseq_s;

   lsseq_s r;
   lsseq_s next_r;
   logic   tick;

   // ==========================================================
   // helpers
   function automatic logic lim_hit(input lsseq_cnt_t cnt, input int lim);
      lim_hit = (cnt >= lsseq_cnt_t'(lim - 1));
   endfunction

   // highest forward voltage string has the lowest cathode code
   function automatic logic [1:0] pick_ref(input logic [`LSSEQ_NCH-1:0] used,
                                           input lsseq_code_t [`LSSEQ_NCH-1:0] code);
      logic [1:0]  idx;
      lsseq_code_t best;
      logic        found;
      idx   = 2'h0;
      best  = '1;
      found = 1'b0;
      for (int i = 0; i < `LSSEQ_NCH; i++) begin
         if (used[i] && (!found || code[i] < best)) begin
            idx   = 2'(i);
            best  = code[i];
            found = 1'b1;
         end
      end
      pick_ref = idx;
   endfunction

   lsseq_timebase #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_timebase (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .tick    (tick)
   );

   // ==========================================================
   // sequencer
   always_comb begin
      logic prot_hit;
      logic [1:0] sel;
      prot_hit = 1'b0;
      sel      = pick_ref(r.used, cathode_code);
      next_r   = r;
      if (r.st != LSSEQ_SHUTDOWN && tick) begin
         next_r.timer = r.timer + lsseq_cnt_t'(1);
         if (!r.blank_done) begin
            next_r.blank = r.blank + lsseq_cnt_t'(1);
            if (lim_hit(r.blank, BLANK_TICKS)) begin
               next_r.blank_done = 1'b1;
            end
         end
         // short low phases are dimming, a long one ends operation
         if (!en_pwm) begin
            next_r.low_cnt = r.low_cnt + lsseq_cnt_t'(1);
         end
      end
      if (en_pwm) begin
         next_r.low_cnt = '0;
      end
      if (r.st != LSSEQ_SHUTDOWN) begin
         if (r.blank_done && ((|(open_string_protection & r.used)) ||
                              (|(shorted_string_protection & r.used)))) begin
            prot_hit = 1'b1;
         end
         if (over_temp || prot_hit) begin
            next_r.fault_oe = 1'b1;
         end
      end
      case (r.st)
         LSSEQ_SHUTDOWN: begin
            if (en_pwm && supply_ok) begin
               next_r.st = LSSEQ_DETECT;
            end
         end
         LSSEQ_DETECT: begin
            if (tick && lim_hit(r.timer, DETECT_TICKS)) begin
               next_r.used     = cs_low;
               next_r.timer    = '0;
               next_r.st       = LSSEQ_SOFTSTART;
               next_r.fb_force = 1'b1;
            end
         end
         LSSEQ_SOFTSTART: begin
            if (tick && lim_hit(r.timer, SS_TICKS)) begin
               next_r.st       = LSSEQ_REGULATE;
               next_r.fb_force = 1'b0;
               next_r.fb_reg   = 1'b1;
            end
         end
         LSSEQ_REGULATE: begin
            next_r.ref_ch   = sel;
            next_r.fb_raise = (cathode_code[sel] < headroom_setpoint);
         end
         default: begin
            next_r.st = LSSEQ_SHUTDOWN;
         end
      endcase
      // drivers follow the dimming input; faults and unused channels keep them off
      if ((r.st == LSSEQ_SOFTSTART || r.st == LSSEQ_REGULATE) && !next_r.fault_oe) begin
         next_r.gate = en_pwm ? r.used : '0;
      end else begin
         next_r.gate = '0;
      end
      if (r.st != LSSEQ_SHUTDOWN && (!supply_ok ||
          (tick && !en_pwm && lim_hit(r.low_cnt, SHDN_TICKS)))) begin
         next_r = '0;
         next_r.st = LSSEQ_SHUTDOWN;
      end
      // registered copy of the state decode so the pin comes from a flop
      next_r.act = (next_r.st != LSSEQ_SHUTDOWN);
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // ==========================================================
   // outputs
   assign gate_en                     = r.gate;
   assign chan_used                   = r.used;
   assign feedback_force_high         = r.fb_force;
   assign dynamic_headroom_regulation = r.fb_reg;
   assign ref_channel                 = r.ref_ch;
   assign feedback_raise              = r.fb_raise;
   assign fault_out                   = r.fault_out;
   assign fault_oe                    = r.fault_oe;
   assign active                      = r.act;

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   chk_start_cond: assert property ((r.st == LSSEQ_SHUTDOWN) ##1 (r.st == LSSEQ_DETECT)
      |-> $past(en_pwm && supply_ok)) else $error("start without enable and supply");
   chk_detect_len: assert property ((r.st == LSSEQ_DETECT) |-> (r.timer < lsseq_cnt_t'(DETECT_TICKS)))
      else $error("detect window overrun");
   chk_used_class: assert property ((r.st == LSSEQ_DETECT) ##1 (r.st == LSSEQ_SOFTSTART)
      |-> (r.used == $past(cs_low))) else $error("channel use misclassified");
   chk_unused_off: assert property ((r.gate & ~r.used) == '0)
      else $error("unused channel driven");
   chk_ss_force: assert property ((r.st == LSSEQ_SOFTSTART) |-> (r.fb_force && !r.fb_reg))
      else $error("feedback not forced in soft-start");
   chk_ref_pick: assert property ((r.st == LSSEQ_REGULATE) ##1 (r.st == LSSEQ_REGULATE)
      |-> (r.ref_ch == $past(pick_ref(r.used, cathode_code))))
      else $error("wrong reference string");
   chk_blank_hold: assert property ((!r.blank_done && !over_temp && !r.fault_oe)
      |=> !r.fault_oe) else $error("protection acted during blanking");
   chk_fault_off: assert property (r.fault_oe |-> (r.gate == '0))
      else $error("drivers on during fault");
   chk_fault_flag: assert property ((r.st != LSSEQ_SHUTDOWN && over_temp && supply_ok && en_pwm)
      |=> r.fault_oe) else $error("fault flag not raised");
   chk_shdn_hold: assert property ((r.st != LSSEQ_SHUTDOWN && supply_ok && en_pwm)
      |=> (r.st != LSSEQ_SHUTDOWN)) else $error("shutdown while enabled");
   chk_cnt_clear: assert property ((r.st == LSSEQ_SHUTDOWN)
      |-> (r.timer == '0 && r.blank == '0 && r.low_cnt == '0))
      else $error("counters not cleared in shutdown");
endmodule

// >>> tb/lsseq_host.sv
// host pwm source model driving the enable/dimming pin
module lsseq_host (
   input  wire logic       sys_clk,
   input  wire logic       run,
   input  wire logic [7:0] period,
   input  wire logic [7:0] high,
   output logic            en_pwm
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt = 8'h00;
   initial en_pwm = 1'b0;
   // duty is high/period; high at or above period gives a steady level
   always @(posedge sys_clk) begin
      cnt <= (cnt + 8'h01 >= period) ? 8'h00 : cnt + 8'h01;
      en_pwm <= run && (cnt < high);
   end
endmodule

// >>> tb/test_lsseq_top.sv
// self-checking bench of the led string start-up sequencer
module test_lsseq_top;
   import lsseq_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic run = 1'b0;
   logic [7:0] period = 8'h01;
   logic [7:0] high = 8'h01;
   logic en_pwm;
   logic supply_ok = 1'b0;
   logic over_temp = 1'b0;
   logic [3:0] cs_low = 4'h0;
   logic [3:0] open_string_protection = 4'h0;
   logic [3:0] shorted_string_protection = 4'h0;
   lsseq_code_t [3:0] cathode_code = {8'h28, 8'h0a, 8'h1e, 8'h32};
   lsseq_code_t headroom_setpoint = 8'h28;
   logic [3:0] gate_en;
   logic [3:0] chan_used;
   logic [1:0] ref_channel;
   logic feedback_force_high, dynamic_headroom_regulation, feedback_raise;
   logic fault_out, fault_oe, active;
   int mismatches = 0;
   int comparisons = 0;
   int n;
   logic dim_en;

   always #5 sys_clk = ~sys_clk;

   lsseq_host lsseq_host_i (.sys_clk(sys_clk), .run(run), .period(period), .high(high),
      .en_pwm(en_pwm));

   // shortened intervals keep the run brief: 4-cycle tick
   lsseq_top #(.TICK_CYCLES(4), .DETECT_TICKS(8), .SS_TICKS(20), .BLANK_TICKS(40),
      .SHDN_TICKS(10)) lsseq_top_i (
      .sys_clk                     (sys_clk),
      .sys_rst                     (sys_rst),
      .en_pwm                      (en_pwm),
      .supply_ok                   (supply_ok),
      .cs_low                      (cs_low),
      .open_string_protection      (open_string_protection),
      .shorted_string_protection   (shorted_string_protection),
      .over_temp                   (over_temp),
      .cathode_code                (cathode_code),
      .headroom_setpoint           (headroom_setpoint),
      .gate_en                     (gate_en),
      .chan_used                   (chan_used),
      .feedback_force_high         (feedback_force_high),
      .dynamic_headroom_regulation (dynamic_headroom_regulation),
      .ref_channel                 (ref_channel),
      .feedback_raise              (feedback_raise),
      .fault_out                   (fault_out),
      .fault_oe                    (fault_oe),
      .active                      (active)
   );

   // ==========================================================
   // helpers
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic step(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask

   task automatic finish_test;
      if (mismatches == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic power_up(input logic [3:0] used);
      @(posedge sys_clk);
      cs_low <= used;
      run <= 1'b1;
      supply_ok <= 1'b1;
      step(3);
      chk(active, 1);
      chk(gate_en, 0);
      n = 0;
      while (n < 100 && feedback_force_high !== 1'b1) begin
         step(1);
         n++;
      end
      chk(n >= 26 && n <= 40, 1);
      chk(chan_used, used);
      step(1);
      chk(gate_en, used);
   endtask

   // ==========================================================
   // tests
   initial begin
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      run <= 1'b1;
      step(20);
      chk(active, 0);
      power_up(4'hb);
      chk(dynamic_headroom_regulation, 0);
      chk(feedback_force_high, 1);
      @(posedge sys_clk);
      open_string_protection <= 4'h5;
      shorted_string_protection <= 4'h4;
      n = 0;
      while (n < 150 && dynamic_headroom_regulation !== 1'b1) begin
         step(1);
         n++;
      end
      chk(n >= 70 && n <= 90, 1);
      chk(feedback_force_high, 0);
      step(2);
      chk(ref_channel, 1);
      chk(feedback_raise, 1);
      @(posedge sys_clk);
      headroom_setpoint <= 8'h14;
      step(3);
      chk(feedback_raise, 0);
      chk(fault_oe, 0);
      chk(gate_en, 4'hb);
      // short low periods are dimming, not shutdown
      @(posedge sys_clk);
      period <= 8'h08;
      high <= 8'h02;
      step(20);
      chk(active, 1);
      // drivers track the dimming input one cycle late
      repeat (8) begin
         dim_en = en_pwm;
         step(1);
         chk(gate_en, dim_en ? 8'h0b : 8'h00);
      end
      @(posedge sys_clk);
      period <= 8'h01;
      high <= 8'h01;
      n = 0;
      while (n < 100 && fault_oe !== 1'b1) begin
         step(1);
         n++;
      end
      chk(n >= 4, 1);
      chk(fault_oe, 1);
      chk(fault_out, 0);
      chk(gate_en, 0);
      @(posedge sys_clk);
      run <= 1'b0;
      open_string_protection <= 4'h0;
      step(30);
      chk(active, 1);
      step(30);
      chk(active, 0);
      chk(fault_oe, 0);
      power_up(4'h6);
      @(posedge sys_clk);
      over_temp <= 1'b1;
      step(2);
      chk(fault_oe, 1);
      chk(gate_en, 0);
      @(posedge sys_clk);
      over_temp <= 1'b0;
      supply_ok <= 1'b0;
      step(3);
      chk(active, 0);
      finish_test();
   end

   initial begin
      step(20000);
      mismatches++;
      finish_test();
   end
endmodule
